// ### include/tpm_cfg.svh
// Address map, field positions, reset values and counts of the gate and power block
`ifndef TPM_CFG_SVH
`define TPM_CFG_SVH
`define TPM_ADDR_POWER_CTL 8'h87
`define TPM_ADDR_POWER_MGMT 8'hc4
`define TPM_ADDR_GATE_A 8'hc7
`define TPM_ADDR_GATE_B 8'hc9
`define TPM_ADDR_WDOG_CTL 8'hd8
`define TPM_ADDR_MEM_CFG 8'hc6
`define TPM_ADDR_ADDR_CFG 8'h9d
`define TPM_ADDR_CLK_SEL 8'h8f
`define TPM_ADDR_WAKE_MASK 8'h9f
`define TPM_XADDR_FLASH_CMD 16'ha025
`define TPM_XADDR_PROG_CLK 16'ha026
`define TPM_XADDR_FLASH_PROT_CTL 16'ha027
`define TPM_XADDR_FLASH_PROT_0 16'ha030
`define TPM_XADDR_BRK_IRQ_EN 16'ha0e1
`define TPM_XADDR_DEBUG_ID 16'ha09f
`define TPM_UNLOCK_FIRST 8'haa
`define TPM_UNLOCK_SECOND 8'h55
`define TPM_GATE_B_CLOSE 8'h00
`define TPM_GATE_B_WINDOW 9'h100
`define TPM_BIT_BAUD_DBL 7
`define TPM_BIT_SLEEP 2
`define TPM_BIT_STOP 1
`define TPM_BIT_IDLE 0
`define TPM_BIT_CD_HIGH 7
`define TPM_BIT_CD_LOW 6
`define TPM_BIT_SWITCH_BACK 5
`define TPM_RST_CD_LOW 1'b1
`define TPM_RST_SWITCH_BACK 1'b0
`define TPM_SETTLE_SEL0 9'h004
`define TPM_SETTLE_SEL1 9'h010
`define TPM_SETTLE_SEL2 9'h040
`define TPM_SETTLE_SEL3 9'h100
`endif

// ### include/tpm_pkg.sv
// Types shared by the gate and power block
package tpm_pkg;
   typedef enum logic [2:0] {PM_RUN, PM_IDLE, PM_STOP, PM_SLEEP, PM_SETTLE} tpm_pwr_e;
   typedef struct packed {
      logic [7:0] addr;
      logic wr;
      logic rd;
      logic [7:0] wdata;
   } tpm_sfr_req_s;
   typedef struct packed {
      logic [15:0] addr;
      logic wr;
   } tpm_xfr_req_s;
   typedef struct packed {
      logic wdog_ctl;
      logic wdog_restart;
      logic mem_cfg;
      logic addr_cfg;
      logic clk_sel;
      logic wake_mask;
      logic xfr;
   } tpm_we_s;
   typedef struct packed {
      logic s1;
      logic s2;
   } tpm_sync_s;
   typedef struct packed {
      logic armed;
   } tpm_seq_s;
   typedef struct packed {
      logic ticket;
      logic [8:0] win_cnt;
      logic b_open;
      tpm_pwr_e pwr;
      logic [8:0] settle_cnt;
      logic [7:0] rdata;
      logic baud_dbl;
      logic cd_low;
      logic switch_back;
      logic slow_d;
      logic wake_d;
      tpm_we_s we;
      logic [7:0] wdata;
      logic [15:0] xaddr;
      logic cpu_clk_stop;
      logic periph_clk_stop;
      logic regulator_off;
      logic integ_rst;
   } tpm_state_s;
endpackage

// ### hw/tpm_sync2.sv
// Two-flop synchroniser for one level
`timescale 1ns/10ps
module tpm_sync2 (
   input wire logic clk,
   input wire logic rst,
   input wire logic d,
   output logic q
);
   tpm_pkg::tpm_sync_s s_r;
   tpm_pkg::tpm_sync_s s_nxt;
   always_comb begin
      s_nxt.s1 = d;
      s_nxt.s2 = s_r.s1;
   end
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         s_r <= '0;
      end else begin
         s_r <= s_nxt;
      end
   end
   assign q = s_r.s2;
endmodule

// ### hw/tpm_unlock_seq.sv
// Two-write unlock sequence detector for one gate address
`timescale 1ns/10ps
`include "tpm_cfg.svh"
module tpm_unlock_seq (
   input wire logic clk,
   input wire logic rst,
   input wire logic sel_wr,
   input wire logic sel_rd,
   input wire logic [7:0] wdata,
   output logic hit
);
   tpm_pkg::tpm_seq_s s_r;
   tpm_pkg::tpm_seq_s s_nxt;
   // Any other value or any read at the address starts over
   always_comb begin
      s_nxt = s_r;
      if (sel_wr) begin
         s_nxt.armed = (wdata == `TPM_UNLOCK_FIRST);
      end else if (sel_rd) begin
         s_nxt.armed = 1'b0;
      end
   end
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         s_r <= '0;
      end else begin
         s_r <= s_nxt;
      end
   end
   assign hit = sel_wr && s_r.armed && (wdata == `TPM_UNLOCK_SECOND);
endmodule

// ### hw/tpm_gate_power.sv
// Timed-access write gates and CPU power-mode control
`timescale 1ns/10ps
`include "tpm_cfg.svh"
module tpm_gate_power (
   input wire logic clk,
   input wire logic rst,
   input tpm_pkg::tpm_sfr_req_s sfr_req,
   input tpm_pkg::tpm_xfr_req_s xfr_req,
   input wire logic wake_event,
   input wire logic slow_32k_clock,
   input wire logic [1:0] regulator_settle_sel,
   output logic [7:0] sfr_rdata,
   output tpm_pkg::tpm_we_s prot_we,
   output logic [7:0] prot_wdata,
   output logic [15:0] prot_xaddr,
   output logic gate_a_unlocked_flag,
   output logic gate_b_open_flag,
   output logic uart0_baud_double,
   output logic cpu_clk_stop,
   output logic periph_clk_stop,
   output logic regulator_off,
   output logic integ_periph_rst
);
   tpm_pkg::tpm_state_s s_r;
   tpm_pkg::tpm_state_s s_nxt;
   logic wake_q;
   logic slow_q;
   logic a_hit;
   logic b_hit;
   logic sel_a;
   logic sel_b;
   logic b_close;
   logic wake_edge;
   logic slow_tick;

   function automatic logic [8:0] settle_len(input logic [1:0] sel);
      logic [8:0] r;
      r = `TPM_SETTLE_SEL3;
      case (sel)
         2'h0: r = `TPM_SETTLE_SEL0;
         2'h1: r = `TPM_SETTLE_SEL1;
         2'h2: r = `TPM_SETTLE_SEL2;
         default: r = `TPM_SETTLE_SEL3;
      endcase
      return r;
   endfunction

   function automatic logic is_gate_b_xfr(input logic [15:0] a);
      return a == `TPM_XADDR_FLASH_CMD || a == `TPM_XADDR_PROG_CLK ||
         a == `TPM_XADDR_FLASH_PROT_CTL || a == `TPM_XADDR_FLASH_PROT_0 ||
         a == `TPM_XADDR_BRK_IRQ_EN || a == `TPM_XADDR_DEBUG_ID;
   endfunction

   // Wake is an outside level; slow clock is sampled as a level
   tpm_sync2 u_wake_sync (
      .clk(clk),
      .rst(rst),
      .d(wake_event),
      .q(wake_q)
   );
   tpm_sync2 u_slow_sync (
      .clk(clk),
      .rst(rst),
      .d(slow_32k_clock),
      .q(slow_q)
   );

   assign sel_a = sfr_req.addr == `TPM_ADDR_GATE_A;
   assign sel_b = sfr_req.addr == `TPM_ADDR_GATE_B;
   assign b_close = sfr_req.wr && sel_b && sfr_req.wdata == `TPM_GATE_B_CLOSE;
   assign wake_edge = wake_q && !s_r.wake_d;
   assign slow_tick = slow_q && !s_r.slow_d;

   tpm_unlock_seq u_seq_a (
      .clk(clk),
      .rst(rst),
      .sel_wr(sfr_req.wr && sel_a),
      .sel_rd(sfr_req.rd && sel_a),
      .wdata(sfr_req.wdata),
      .hit(a_hit)
   );
   tpm_unlock_seq u_seq_b (
      .clk(clk),
      .rst(rst),
      .sel_wr(sfr_req.wr && sel_b),
      .sel_rd(sfr_req.rd && sel_b),
      .wdata(sfr_req.wdata),
      .hit(b_hit)
   );

   always_comb begin
      s_nxt = s_r;
      s_nxt.we = '0;
      s_nxt.wake_d = wake_q;
      s_nxt.slow_d = slow_q;
      s_nxt.wdata = sfr_req.wdata;
      s_nxt.xaddr = xfr_req.addr;

      // Gate A ticket; grant wins over the cancel by the same access
      if (sel_a && (sfr_req.wr || sfr_req.rd)) begin
         s_nxt.ticket = 1'b0;
      end
      if (a_hit) begin
         s_nxt.ticket = 1'b1;
      end
      if (sfr_req.wr && s_r.ticket) begin
         unique case (sfr_req.addr)
            `TPM_ADDR_MEM_CFG: begin
               s_nxt.we.mem_cfg = 1'b1;
               s_nxt.ticket = 1'b0;
            end
            `TPM_ADDR_ADDR_CFG: begin
               s_nxt.we.addr_cfg = 1'b1;
               s_nxt.ticket = 1'b0;
            end
            `TPM_ADDR_WDOG_CTL: begin
               s_nxt.we.wdog_restart = 1'b1;
               s_nxt.ticket = 1'b0;
            end
            default: begin
            end
         endcase
      end
      // Watchdog control other bits are not protected
      if (sfr_req.wr && sfr_req.addr == `TPM_ADDR_WDOG_CTL) begin
         s_nxt.we.wdog_ctl = 1'b1;
      end

      // Gate B window; counter frozen while the CPU clock is stopped
      if (s_r.win_cnt != 9'h000 && !s_r.cpu_clk_stop) begin
         s_nxt.win_cnt = s_r.win_cnt - 9'h001;
      end
      if (b_close) begin
         s_nxt.win_cnt = 9'h000;
      end
      if (b_hit) begin
         s_nxt.win_cnt = `TPM_GATE_B_WINDOW;
      end
      s_nxt.b_open = s_nxt.win_cnt != 9'h000;
      if (s_r.win_cnt != 9'h000) begin
         s_nxt.we.clk_sel = sfr_req.wr && sfr_req.addr == `TPM_ADDR_CLK_SEL;
         s_nxt.we.wake_mask = sfr_req.wr && sfr_req.addr == `TPM_ADDR_WAKE_MASK;
         s_nxt.we.xfr = xfr_req.wr && is_gate_b_xfr(xfr_req.addr);
      end

      // Power mode sequencing
      unique case (s_r.pwr)
         tpm_pkg::PM_RUN: begin
            if (sfr_req.wr && sfr_req.addr == `TPM_ADDR_POWER_CTL) begin
               s_nxt.baud_dbl = sfr_req.wdata[`TPM_BIT_BAUD_DBL];
               if (sfr_req.wdata[`TPM_BIT_STOP] && sfr_req.wdata[`TPM_BIT_SLEEP]) begin
                  s_nxt.pwr = tpm_pkg::PM_SLEEP;
               end else if (sfr_req.wdata[`TPM_BIT_STOP]) begin
                  s_nxt.pwr = tpm_pkg::PM_STOP;
               end else if (sfr_req.wdata[`TPM_BIT_IDLE]) begin
                  s_nxt.pwr = tpm_pkg::PM_IDLE;
               end
            end
         end
         tpm_pkg::PM_IDLE, tpm_pkg::PM_STOP: begin
            if (wake_edge) begin
               s_nxt.pwr = tpm_pkg::PM_RUN;
            end
         end
         tpm_pkg::PM_SLEEP: begin
            if (wake_edge) begin
               s_nxt.pwr = tpm_pkg::PM_SETTLE;
               s_nxt.settle_cnt = settle_len(regulator_settle_sel);
            end
         end
         tpm_pkg::PM_SETTLE: begin
            if (slow_tick) begin
               if (s_r.settle_cnt == 9'h001) begin
                  s_nxt.pwr = tpm_pkg::PM_RUN;
               end
               s_nxt.settle_cnt = s_r.settle_cnt - 9'h001;
            end
         end
         default: begin
            s_nxt.pwr = tpm_pkg::PM_RUN;
         end
      endcase
      s_nxt.cpu_clk_stop = s_nxt.pwr != tpm_pkg::PM_RUN;
      s_nxt.periph_clk_stop = s_nxt.pwr == tpm_pkg::PM_STOP ||
         s_nxt.pwr == tpm_pkg::PM_SLEEP || s_nxt.pwr == tpm_pkg::PM_SETTLE;
      s_nxt.regulator_off = s_nxt.pwr == tpm_pkg::PM_SLEEP;
      s_nxt.integ_rst = s_nxt.pwr == tpm_pkg::PM_IDLE;

      // Power management: divider high bit stays zero, switch-back inert
      if (sfr_req.wr && sfr_req.addr == `TPM_ADDR_POWER_MGMT) begin
         s_nxt.cd_low = sfr_req.wdata[`TPM_BIT_CD_LOW];
         s_nxt.switch_back = sfr_req.wdata[`TPM_BIT_SWITCH_BACK];
      end

      // Register read data, one cycle after the read strobe
      if (sfr_req.rd) begin
         s_nxt.rdata = 8'h00;
         unique case (sfr_req.addr)
            `TPM_ADDR_GATE_A: s_nxt.rdata[0] = s_r.ticket;
            `TPM_ADDR_GATE_B: s_nxt.rdata[0] = s_r.win_cnt != 9'h000;
            `TPM_ADDR_POWER_CTL: s_nxt.rdata[`TPM_BIT_BAUD_DBL] = s_r.baud_dbl;
            `TPM_ADDR_POWER_MGMT: begin
               s_nxt.rdata[`TPM_BIT_CD_HIGH] = 1'b0;
               s_nxt.rdata[`TPM_BIT_CD_LOW] = s_r.cd_low;
               s_nxt.rdata[`TPM_BIT_SWITCH_BACK] = s_r.switch_back;
            end
            default: begin
            end
         endcase
      end
   end

   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         s_r <= '0;
         s_r.cd_low <= `TPM_RST_CD_LOW;
         s_r.switch_back <= `TPM_RST_SWITCH_BACK;
      end else begin
         s_r <= s_nxt;
      end
   end

   assign sfr_rdata = s_r.rdata;
   assign prot_we = s_r.we;
   assign prot_wdata = s_r.wdata;
   assign prot_xaddr = s_r.xaddr;
   assign gate_a_unlocked_flag = s_r.ticket;
   assign gate_b_open_flag = s_r.b_open;
   assign uart0_baud_double = s_r.baud_dbl;
   assign cpu_clk_stop = s_r.cpu_clk_stop;
   assign periph_clk_stop = s_r.periph_clk_stop;
   assign regulator_off = s_r.regulator_off;
   assign integ_periph_rst = s_r.integ_rst;

   default clocking cb @(posedge clk);
   endclocking
   default disable iff (rst);

   property p_grant;
      sfr_req.wr && sel_a && sfr_req.wdata == 8'haa
         ##1 sfr_req.wr && sel_a && sfr_req.wdata == 8'h55 |=> s_r.ticket;
   endproperty
   a_grant: assert property (p_grant) else $error("gate A not granted");

   property p_single;
      sfr_req.wr && sfr_req.addr == 8'hc6 && s_r.ticket |=> !s_r.ticket && s_r.we.mem_cfg;
   endproperty
   a_single: assert property (p_single) else $error("ticket not used up");

   property p_locked;
      sfr_req.wr && sfr_req.addr == 8'hc6 && !s_r.ticket |=> !s_r.we.mem_cfg;
   endproperty
   a_locked: assert property (p_locked) else $error("locked write passed");

   property p_cancel;
      sfr_req.rd && sel_a |=> !s_r.ticket && sfr_rdata[0] == $past(s_r.ticket);
   endproperty
   a_cancel: assert property (p_cancel) else $error("gate A read wrong");

   property p_window;
      b_hit |=> s_r.win_cnt == 9'h100 && gate_b_open_flag;
   endproperty
   a_window: assert property (p_window) else $error("window not opened");

   property p_close;
      b_close |=> !gate_b_open_flag;
   endproperty
   a_close: assert property (p_close) else $error("window not closed");

   property p_hold;
      s_r.cpu_clk_stop && !b_hit && !b_close |=> $stable(s_r.win_cnt);
   endproperty
   a_hold: assert property (p_hold) else $error("window ran while stopped");

   property p_stop_wake;
      s_r.pwr == tpm_pkg::PM_STOP && wake_edge |=> !cpu_clk_stop && !periph_clk_stop;
   endproperty
   a_stop_wake: assert property (p_stop_wake) else $error("STOP did not exit");

   property p_sleep;
      s_r.pwr == tpm_pkg::PM_SLEEP |-> regulator_off && periph_clk_stop;
   endproperty
   a_sleep: assert property (p_sleep) else $error("SLEEP outputs wrong");

   property p_cd_zero;
      sfr_req.rd && sfr_req.addr == 8'hc4 |=> !sfr_rdata[7];
   endproperty
   a_cd_zero: assert property (p_cd_zero) else $error("divider bit not zero");

   property p_read_free;
      sfr_req.rd && sfr_req.addr == 8'hc6 |=> $stable(gate_a_unlocked_flag);
   endproperty
   a_read_free: assert property (p_read_free) else $error("protected read moved ticket");

   property p_b_locked;
      sfr_req.wr && sfr_req.addr == 8'h8f && !gate_b_open_flag |=> !prot_we.clk_sel;
   endproperty
   a_b_locked: assert property (p_b_locked) else $error("closed window passed write");

   property p_b_open;
      sfr_req.wr && sfr_req.addr == 8'h8f && gate_b_open_flag |=> prot_we.clk_sel;
   endproperty
   a_b_open: assert property (p_b_open) else $error("open window blocked write");

   property p_idle;
      s_r.pwr == tpm_pkg::PM_IDLE |-> cpu_clk_stop && integ_periph_rst && !periph_clk_stop;
   endproperty
   a_idle: assert property (p_idle) else $error("IDLE outputs wrong");

   property p_settle_end;
      s_r.pwr == tpm_pkg::PM_SETTLE && slow_tick && s_r.settle_cnt == 9'h001
         |=> !cpu_clk_stop;
   endproperty
   a_settle_end: assert property (p_settle_end) else $error("settle did not end");

   property p_baud;
      sfr_req.wr && sfr_req.addr == 8'h87 && s_r.pwr == tpm_pkg::PM_RUN
         |=> uart0_baud_double == prot_wdata[7];
   endproperty
   a_baud: assert property (p_baud) else $error("baud double not taken");
endmodule

// ### tb/tpm_gate_power_bench.sv
// Self-checking bench for the timed-access gates and power-mode control
`timescale 1ns/10ps
`include "tpm_cfg.svh"
module tpm_gate_power_bench;
   logic clk, rst, wake_event, slow_32k_clock;
   logic [1:0] regulator_settle_sel;
   tpm_pkg::tpm_sfr_req_s sfr_req;
   tpm_pkg::tpm_xfr_req_s xfr_req;
   tpm_pkg::tpm_we_s prot_we;
   logic [7:0] sfr_rdata, prot_wdata;
   logic [15:0] prot_xaddr;
   logic gate_a_unlocked_flag, gate_b_open_flag, uart0_baud_double;
   logic cpu_clk_stop, periph_clk_stop, regulator_off, integ_periph_rst;
   logic [15:0] xa [6] = '{16'ha025, 16'ha026, 16'ha027, 16'ha030, 16'ha0e1, 16'ha09f};
   int n_fail = 0;
   int num_checks = 0;

   tpm_gate_power tpm_gate_power_i (
      .clk(clk), .rst(rst), .sfr_req(sfr_req), .xfr_req(xfr_req),
      .wake_event(wake_event), .slow_32k_clock(slow_32k_clock),
      .regulator_settle_sel(regulator_settle_sel), .sfr_rdata(sfr_rdata),
      .prot_we(prot_we), .prot_wdata(prot_wdata), .prot_xaddr(prot_xaddr),
      .gate_a_unlocked_flag(gate_a_unlocked_flag), .gate_b_open_flag(gate_b_open_flag),
      .uart0_baud_double(uart0_baud_double), .cpu_clk_stop(cpu_clk_stop),
      .periph_clk_stop(periph_clk_stop), .regulator_off(regulator_off),
      .integ_periph_rst(integ_periph_rst)
   );

   initial begin
      clk = 1'b0;
      forever #12.5 clk = ~clk;
   end

   // Inputs always change 2 ns after a rising edge
   // Bus strobes drop at the start of every idle wait
   task automatic cyc(input int n);
      sfr_req.wr = 1'b0;
      sfr_req.rd = 1'b0;
      xfr_req.wr = 1'b0;
      repeat (n) @(posedge clk);
      #2;
   endtask

   task automatic chk(input string name, input logic [15:0] exp, input logic [15:0] got);
      num_checks++;
      if (got !== exp) begin
         n_fail++;
         $display("[ERR] %s expected %h seen %h", name, exp, got);
      end
   endtask

   // One access; its strobe stays up until the next access or idle wait
   task automatic drive(input tpm_pkg::tpm_sfr_req_s s, input tpm_pkg::tpm_xfr_req_s x);
      sfr_req = s;
      xfr_req = x;
      @(posedge clk);
      #2;
   endtask

   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      drive('{addr: a, wr: 1'b1, rd: 1'b0, wdata: d}, '0);
   endtask

   task automatic rd(input logic [7:0] a);
      drive('{addr: a, wr: 1'b0, rd: 1'b1, wdata: 8'h00}, '0);
   endtask

   task automatic xwr(input logic [15:0] a);
      drive('0, '{addr: a, wr: 1'b1});
   endtask

   task automatic unlock(input logic [7:0] a);
      wr(a, `TPM_UNLOCK_FIRST);
      wr(a, `TPM_UNLOCK_SECOND);
   endtask

   // Wake request, then bounded wait for the CPU clock to return
   task automatic wake_up(input int lim);
      int i;
      wake_event = 1'b1;
      for (i = 0; i < lim && cpu_clk_stop !== 1'b0; i++) cyc(1);
      chk("cpu_clk_stop", 16'h0, {15'h0, cpu_clk_stop});
      wake_event = 1'b0;
      cyc(3);
   endtask

   task automatic tick(input int n);
      repeat (n) begin
         slow_32k_clock = 1'b1;
         cyc(3);
         slow_32k_clock = 1'b0;
         cyc(3);
      end
   endtask

   task automatic complete_run();
      $display("checks %0d mismatches %0d", num_checks, n_fail);
      if (n_fail == 0 && num_checks > 0) $display("All checks passed");
      else $display("Checks failed");
      $finish;
   endtask

   initial begin
      #(25 * 8000);
      n_fail++;
      complete_run();
   end

   initial begin
      rst = 1'b1;
      wake_event = 1'b0;
      slow_32k_clock = 1'b0;
      regulator_settle_sel = 2'h0;
      sfr_req = '0;
      xfr_req = '0;
      repeat (3) @(posedge clk);
      #2;
      rst = 1'b0;
      rd(`TPM_ADDR_POWER_MGMT);
      chk("pwr_mgmt", 16'h40, {8'h0, sfr_rdata});
      rd(`TPM_ADDR_GATE_A);
      chk("gate_a_rd", 16'h0, {8'h0, sfr_rdata});
      wr(`TPM_ADDR_MEM_CFG, 8'h01);
      chk("we_locked", 16'h0, {9'h0, prot_we});
      wr(`TPM_ADDR_WDOG_CTL, 8'hff);
      chk("we_wdog_locked", 16'h40, {9'h0, prot_we});
      unlock(`TPM_ADDR_GATE_A);
      chk("ticket", 16'h1, {15'h0, gate_a_unlocked_flag});
      wr(`TPM_ADDR_MEM_CFG, 8'h5a);
      chk("we_mem_cfg", 16'h10, {9'h0, prot_we});
      chk("wdata", 16'h5a, {8'h0, prot_wdata});
      chk("ticket_used", 16'h0, {15'h0, gate_a_unlocked_flag});
      wr(`TPM_ADDR_ADDR_CFG, 8'h03);
      chk("we_relock", 16'h0, {9'h0, prot_we});
      unlock(`TPM_ADDR_GATE_A);
      wr(`TPM_ADDR_WDOG_CTL, 8'hff);
      chk("we_wdog_restart", 16'h60, {9'h0, prot_we});
      unlock(`TPM_ADDR_GATE_A);
      wr(`TPM_ADDR_ADDR_CFG, 8'h03);
      chk("we_addr_cfg", 16'h08, {9'h0, prot_we});
      wr(`TPM_ADDR_GATE_A, 8'haa);
      rd(`TPM_ADDR_GATE_A);
      wr(`TPM_ADDR_GATE_A, 8'h55);
      chk("seq_rd_break", 16'h0, {15'h0, gate_a_unlocked_flag});
      wr(`TPM_ADDR_GATE_A, 8'haa);
      wr(`TPM_ADDR_GATE_A, 8'h12);
      wr(`TPM_ADDR_GATE_A, 8'h55);
      chk("seq_val_break", 16'h0, {15'h0, gate_a_unlocked_flag});
      wr(`TPM_ADDR_GATE_A, 8'haa);
      rd(`TPM_ADDR_MEM_CFG);
      wr(`TPM_ADDR_GATE_A, 8'h55);
      cyc(50);
      chk("ticket_kept", 16'h1, {15'h0, gate_a_unlocked_flag});
      rd(`TPM_ADDR_GATE_A);
      chk("gate_a_stat", 16'h1, {8'h0, sfr_rdata});
      chk("ticket_void", 16'h0, {15'h0, gate_a_unlocked_flag});
      $display("test gate_a done");

      wr(`TPM_ADDR_CLK_SEL, 8'h0c);
      chk("we_b_locked", 16'h0, {9'h0, prot_we});
      unlock(`TPM_ADDR_GATE_B);
      chk("window", 16'h1, {15'h0, gate_b_open_flag});
      wr(`TPM_ADDR_CLK_SEL, 8'h0c);
      chk("we_clk_sel", 16'h04, {9'h0, prot_we});
      wr(`TPM_ADDR_WAKE_MASK, 8'hff);
      chk("we_wake_mask", 16'h02, {9'h0, prot_we});
      foreach (xa[i]) begin
         xwr(xa[i]);
         chk("we_xfr", 16'h01, {9'h0, prot_we});
         chk("xaddr", xa[i], prot_xaddr);
      end
      rd(`TPM_ADDR_GATE_B);
      chk("gate_b_stat", 16'h1, {8'h0, sfr_rdata});
      cyc(150);
      unlock(`TPM_ADDR_GATE_B);
      cyc(255);
      chk("window_end-1", 16'h1, {15'h0, gate_b_open_flag});
      cyc(1);
      chk("window_end", 16'h0, {15'h0, gate_b_open_flag});
      xwr(16'ha025);
      chk("we_xfr_closed", 16'h0, {9'h0, prot_we});
      rd(`TPM_ADDR_GATE_B);
      chk("gate_b_stat0", 16'h0, {8'h0, sfr_rdata});
      unlock(`TPM_ADDR_GATE_B);
      wr(`TPM_ADDR_GATE_B, `TPM_GATE_B_CLOSE);
      chk("window_closed", 16'h0, {15'h0, gate_b_open_flag});
      $display("test gate_b done");

      wr(`TPM_ADDR_POWER_CTL, 8'h80);
      chk("baud_dbl", 16'h1, {15'h0, uart0_baud_double});
      rd(`TPM_ADDR_POWER_CTL);
      chk("pwr_ctl_rd", 16'h80, {8'h0, sfr_rdata});
      wr(`TPM_ADDR_POWER_CTL, 8'h00);
      chk("baud_clr", 16'h0, {15'h0, uart0_baud_double});
      wr(`TPM_ADDR_POWER_MGMT, 8'hff);
      rd(`TPM_ADDR_POWER_MGMT);
      chk("pwr_mgmt_wr", 16'h60, {8'h0, sfr_rdata});
      wr(`TPM_ADDR_POWER_MGMT, 8'h00);
      rd(`TPM_ADDR_POWER_MGMT);
      chk("pwr_mgmt_clr", 16'h0, {8'h0, sfr_rdata});
      unlock(`TPM_ADDR_GATE_B);
      wr(`TPM_ADDR_POWER_CTL, 8'h02);
      chk("stop_clk", 16'h3, {14'h0, cpu_clk_stop, periph_clk_stop});
      chk("stop_reg", 16'h0, {15'h0, regulator_off});
      cyc(300);
      chk("frozen_win", 16'h1, {15'h0, gate_b_open_flag});
      wake_up(10);
      chk("after_wake_win", 16'h1, {15'h0, gate_b_open_flag});
      wr(`TPM_ADDR_GATE_B, `TPM_GATE_B_CLOSE);
      wr(`TPM_ADDR_POWER_CTL, 8'h01);
      chk("idle", 16'h5, {13'h0, cpu_clk_stop, periph_clk_stop, integ_periph_rst});
      wake_up(10);
      chk("idle_rst", 16'h0, {15'h0, integ_periph_rst});
      wr(`TPM_ADDR_POWER_CTL, 8'h06);
      chk("sleep", 16'h7, {13'h0, cpu_clk_stop, periph_clk_stop, regulator_off});
      wake_event = 1'b1;
      cyc(5);
      chk("settle", 16'h2, {14'h0, cpu_clk_stop, regulator_off});
      tick(3);
      chk("settle_3", 16'h1, {15'h0, cpu_clk_stop});
      tick(1);
      wake_up(10);
      regulator_settle_sel = 2'h1;
      wr(`TPM_ADDR_POWER_CTL, 8'h06);
      wake_event = 1'b1;
      cyc(5);
      tick(15);
      chk("settle_15", 16'h1, {15'h0, cpu_clk_stop});
      tick(1);
      chk("settle_16", 16'h0, {15'h0, cpu_clk_stop});
      wake_event = 1'b0;
      $display("test power done");
      complete_run();
   end
endmodule
